// ---- hdl/wdt_pkg.sv ----
// Purpose: Shared constants and types for the config port watchdog
// Assumes: 125 MHz core clock, 8-bit host I/O port cycles
// Notes: Register indices are the values written to the index port
package wdt_pkg;
    localparam logic [7:0] INDEX_PORT_ADDR = 8'h2e;
    localparam logic [7:0] DATA_PORT_ADDR = 8'h2f;
    localparam logic [7:0] UNLOCK_KEY = 8'h87;
    localparam logic [7:0] LOCK_KEY = 8'haa;
    localparam logic [7:0] REG_UNIT_SELECT = 8'h07;
    localparam logic [7:0] REG_ACTIVATE = 8'h30;
    localparam logic [7:0] REG_UNIT_CFG = 8'hf5;
    localparam logic [7:0] REG_COUNT = 8'hf6;
    localparam logic [7:0] REG_RESTART_STATUS = 8'hf7;
    localparam logic [7:0] WATCHDOG_UNIT = 8'h08;
    localparam logic [7:0] ACTIVATE_ON = 8'h01;
    localparam int MINUTES_BIT = 3;
    localparam int MOUSE_EN_BIT = 7;
    localparam int KBD_EN_BIT = 6;
    localparam int FORCE_BIT = 5;
    localparam int STATUS_BIT = 4;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam int CLK_HZ = 125_000_000;
    localparam int SECOND_NS = 1_000_000_000;
    localparam int CLK_PERIOD_NS = 8;
    localparam int CYCLES_PER_SECOND = SECOND_NS / CLK_PERIOD_NS;
    localparam int SECONDS_PER_MINUTE = 60;

    // One host I/O cycle toward the device
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } io_req_t;
endpackage

// ---- hdl/config_port_watchdog.sv ----
// Purpose: Watchdog timer behind a locked index/data host port pair
// Assumes: Host strobes are one-cycle pulses on core_clk_in
// Notes: Activity and strap inputs come from pins and are synchronised
// Contract
// - Index and data host ports reach registers
// - Unlock key twice enters configuration mode
// - Lock key leaves configuration mode
// - Unit number eight selects watchdog registers
// - Activation 01 enables; disabled after reset
// - Units bit: zero seconds, one minutes
// - Count zero stops; 1 to 255 units
// - Count write reloads and restarts counter
// - Expiry asserts timeout output
// - Interrupt active low until restarted
// - Strap routes timeout to reset or interrupt
// - Keyboard restart bit, default off
// - Force bit raises timeout, self clears
// - Status bit reads one after timeout
// - Mouse restart bit enables mouse restart
module config_port_watchdog #(
    parameter int SECOND_CYCLES = wdt_pkg::CYCLES_PER_SECOND,
    parameter int MINUTE_SECONDS = wdt_pkg::SECONDS_PER_MINUTE
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire wdt_pkg::io_req_t io_req_in,
    output logic [7:0] io_rdata_out,
    input wire logic kbd_activity_in,
    input wire logic mouse_activity_in,
    input wire logic timeout_route_strap_in,
    output logic timeout_irq_n_out,
    output logic timeout_reset_out
);
    import wdt_pkg::*;

    typedef enum logic [1:0] {LOCKED, HALF_OPEN, OPEN} cfg_state_t;

    cfg_state_t cfg_state_reg;
    logic [7:0] index_reg;
    logic [7:0] unit_sel_reg;
    logic active_reg;
    logic minutes_reg;
    logic kbd_en_reg;
    logic mouse_en_reg;
    logic [7:0] count_reg;
    logic [7:0] reload_reg;
    logic [31:0] tick_reg;
    logic [7:0] sec_reg;
    logic expired_reg;
    logic [7:0] io_rdata_reg;
    logic [1:0] kbd_sync_reg;
    logic [1:0] mouse_sync_reg;
    logic [1:0] strap_sync_reg;
    logic kbd_prev_reg;
    logic mouse_prev_reg;

    logic idx_wr;
    logic data_wr;
    logic data_rd;
    logic wd_sel;
    logic count_wr;
    logic force_wr;
    logic kbd_edge;
    logic mouse_edge;
    logic restart;
    logic unit_tick;
    logic expire_now;

    // Index and data port decode; data port only live when unlocked
    assign idx_wr = io_req_in.wr && (io_req_in.addr == INDEX_PORT_ADDR);
    assign data_wr = io_req_in.wr && (io_req_in.addr == DATA_PORT_ADDR)
                     && (cfg_state_reg == OPEN);
    assign data_rd = io_req_in.rd && (io_req_in.addr == DATA_PORT_ADDR)
                     && (cfg_state_reg == OPEN);
    assign wd_sel = (unit_sel_reg == WATCHDOG_UNIT);
    assign count_wr = data_wr && wd_sel && (index_reg == REG_COUNT);
    assign force_wr = data_wr && wd_sel && (index_reg == REG_RESTART_STATUS)
                      && io_req_in.wdata[FORCE_BIT];

    // Pin synchronisers for activity and strap
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            kbd_sync_reg <= 2'h0;
            mouse_sync_reg <= 2'h0;
            strap_sync_reg <= 2'h0;
            kbd_prev_reg <= 1'b0;
            mouse_prev_reg <= 1'b0;
        end else begin
            kbd_sync_reg <= {kbd_sync_reg[0], kbd_activity_in};
            mouse_sync_reg <= {mouse_sync_reg[0], mouse_activity_in};
            strap_sync_reg <= {strap_sync_reg[0], timeout_route_strap_in};
            kbd_prev_reg <= kbd_sync_reg[1];
            mouse_prev_reg <= mouse_sync_reg[1];
        end
    end

    assign kbd_edge = kbd_sync_reg[1] && !kbd_prev_reg;
    assign mouse_edge = mouse_sync_reg[1] && !mouse_prev_reg;
    assign restart = count_wr || (kbd_en_reg && kbd_edge)
                     || (mouse_en_reg && mouse_edge);

    // Key sequence: two unlock writes in a row open, lock key closes
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cfg_state_reg <= LOCKED;
        end else if (idx_wr) begin
            case (cfg_state_reg)
                LOCKED: begin
                    cfg_state_reg <= (io_req_in.wdata == UNLOCK_KEY) ? HALF_OPEN
                                                                      : LOCKED;
                end
                HALF_OPEN: begin
                    cfg_state_reg <= (io_req_in.wdata == UNLOCK_KEY) ? OPEN : LOCKED;
                end
                OPEN: begin
                    if (io_req_in.wdata == LOCK_KEY) begin
                        cfg_state_reg <= LOCKED;
                    end
                end
                default: begin
                    cfg_state_reg <= LOCKED;
                end
            endcase
        end
    end

    // Index register, only loaded while configuration is open
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            index_reg <= 8'h00;
        end else if (idx_wr && cfg_state_reg == OPEN) begin
            index_reg <= io_req_in.wdata;
        end
    end

    // Configuration registers written through the data port
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            unit_sel_reg <= 8'h00;
            active_reg <= 1'b0;
            minutes_reg <= 1'b0;
            kbd_en_reg <= 1'b0;
            mouse_en_reg <= 1'b0;
        end else if (data_wr) begin
            if (index_reg == REG_UNIT_SELECT) begin
                unit_sel_reg <= io_req_in.wdata;
            end else if (wd_sel) begin
                case (index_reg)
                    REG_ACTIVATE: begin
                        active_reg <= (io_req_in.wdata == ACTIVATE_ON);
                    end
                    REG_UNIT_CFG: begin
                        minutes_reg <= io_req_in.wdata[MINUTES_BIT];
                    end
                    REG_RESTART_STATUS: begin
                        kbd_en_reg <= io_req_in.wdata[KBD_EN_BIT];
                        mouse_en_reg <= io_req_in.wdata[MOUSE_EN_BIT];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Unit prescaler: second ticks, then minutes by counting seconds
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            tick_reg <= 32'h0;
            sec_reg <= 8'h00;
        end else if (restart || !active_reg || count_reg == COUNT_RESET) begin
            tick_reg <= 32'h0;
            sec_reg <= 8'h00;
        end else if (tick_reg == 32'(SECOND_CYCLES - 1)) begin
            tick_reg <= 32'h0;
            if (unit_tick) begin
                sec_reg <= 8'h00;
            end else begin
                sec_reg <= sec_reg + 8'h01;
            end
        end else begin
            tick_reg <= tick_reg + 32'h1;
        end
    end

    assign unit_tick = (tick_reg == 32'(SECOND_CYCLES - 1))
                       && (!minutes_reg || sec_reg == 8'(MINUTE_SECONDS - 1));
    assign expire_now = active_reg && !restart && unit_tick
                        && (count_reg == 8'h01);

    // Count last written, so activity restarts begin again from the full length
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            reload_reg <= COUNT_RESET;
        end else if (count_wr) begin
            reload_reg <= io_req_in.wdata;
        end
    end

    // Down counter: reload on restart, stop at zero
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            count_reg <= COUNT_RESET;
        end else if (count_wr) begin
            count_reg <= io_req_in.wdata;
        end else if (restart) begin
            count_reg <= reload_reg;
        end else if (active_reg && unit_tick && count_reg != COUNT_RESET) begin
            count_reg <= count_reg - 8'h01;
        end
    end

    // Timeout state: set by expiry or force, cleared by restart
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            expired_reg <= 1'b0;
        end else if (expire_now || force_wr) begin
            expired_reg <= 1'b1;
        end else if (restart) begin
            expired_reg <= 1'b0;
        end
    end

    // Data port read path
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            io_rdata_reg <= 8'h00;
        end else if (data_rd) begin
            io_rdata_reg <= 8'h00;
            if (wd_sel && index_reg == REG_RESTART_STATUS) begin
                io_rdata_reg[MOUSE_EN_BIT] <= mouse_en_reg;
                io_rdata_reg[KBD_EN_BIT] <= kbd_en_reg;
                io_rdata_reg[STATUS_BIT] <= expired_reg;
            end else if (wd_sel && index_reg == REG_UNIT_CFG) begin
                io_rdata_reg[MINUTES_BIT] <= minutes_reg;
            end else if (wd_sel && index_reg == REG_COUNT) begin
                io_rdata_reg <= count_reg;
            end
        end
    end

    assign io_rdata_out = io_rdata_reg;
    // Strap steers the timeout to one of the two outputs
    assign timeout_irq_n_out = !(expired_reg && !strap_sync_reg[1]);
    assign timeout_reset_out = expired_reg && strap_sync_reg[1];

    // Assertions
    sequence s_first_key;
        idx_wr && io_req_in.wdata == UNLOCK_KEY && cfg_state_reg == LOCKED;
    endsequence
    sequence s_second_key;
        idx_wr && io_req_in.wdata == UNLOCK_KEY && cfg_state_reg == HALF_OPEN;
    endsequence
    sequence s_wrong_key;
        idx_wr && io_req_in.wdata != UNLOCK_KEY && cfg_state_reg == HALF_OPEN;
    endsequence

    property p_half_open;
        @(posedge core_clk_in) disable iff (rst_in)
        s_first_key |=> cfg_state_reg == HALF_OPEN;
    endproperty
    a_half_open: assert property (p_half_open) else $error("first key lost");

    property p_unlock;
        @(posedge core_clk_in) disable iff (rst_in)
        s_second_key |=> cfg_state_reg == OPEN;
    endproperty
    a_unlock: assert property (p_unlock) else $error("unlock failed");

    property p_wrong_key;
        @(posedge core_clk_in) disable iff (rst_in)
        s_wrong_key |=> cfg_state_reg == LOCKED;
    endproperty
    a_wrong_key: assert property (p_wrong_key) else $error("broken key opened");

    property p_lock;
        @(posedge core_clk_in) disable iff (rst_in)
        idx_wr && io_req_in.wdata == LOCK_KEY && cfg_state_reg == OPEN
        |=> cfg_state_reg == LOCKED;
    endproperty
    a_lock: assert property (p_lock) else $error("lock failed");

    property p_locked_ignore;
        @(posedge core_clk_in) disable iff (rst_in)
        cfg_state_reg != OPEN |=> $stable(index_reg) && $stable(unit_sel_reg)
            && $stable(active_reg) && $stable(minutes_reg) && $stable(kbd_en_reg)
            && ($stable(count_reg) || $past(unit_tick) || $past(restart));
    endproperty
    a_locked_ignore: assert property (p_locked_ignore) else $error("locked change");

    property p_reload;
        @(posedge core_clk_in) disable iff (rst_in)
        count_wr |=> count_reg == $past(io_req_in.wdata) && tick_reg == 32'h0;
    endproperty
    a_reload: assert property (p_reload) else $error("count not reloaded");

    property p_expire;
        @(posedge core_clk_in) disable iff (rst_in)
        expire_now |=> expired_reg ##1 (count_reg == 8'h00 || count_wr || expired_reg);
    endproperty
    a_expire: assert property (p_expire) else $error("expiry lost");

    property p_force;
        @(posedge core_clk_in) disable iff (rst_in)
        force_wr |=> expired_reg;
    endproperty
    a_force: assert property (p_force) else $error("force ignored");

    property p_irq_hold;
        @(posedge core_clk_in) disable iff (rst_in)
        !timeout_irq_n_out && !restart && strap_sync_reg[0] == strap_sync_reg[1]
        |=> !timeout_irq_n_out;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq released early");

    property p_route;
        @(posedge core_clk_in) disable iff (rst_in)
        !(timeout_reset_out && !timeout_irq_n_out);
    endproperty
    a_route: assert property (p_route) else $error("both outputs active");

    property p_zero_stop;
        @(posedge core_clk_in) disable iff (rst_in)
        count_reg == 8'h00 && !restart |=> count_reg == 8'h00;
    endproperty
    a_zero_stop: assert property (p_zero_stop) else $error("zero count moved");

    property p_kbd_reload;
        @(posedge core_clk_in) disable iff (rst_in)
        restart && !count_wr && !force_wr |=> count_reg == $past(reload_reg) && !expired_reg;
    endproperty
    a_kbd_reload: assert property (p_kbd_reload) else $error("activity restart lost");

    property p_status_read;
        @(posedge core_clk_in) disable iff (rst_in)
        data_rd && wd_sel && index_reg == REG_RESTART_STATUS
        |=> io_rdata_out[STATUS_BIT] == $past(expired_reg);
    endproperty
    a_status_read: assert property (p_status_read) else $error("status bit wrong");

    property p_rdata_locked;
        @(posedge core_clk_in) disable iff (rst_in)
        cfg_state_reg != OPEN |=> $stable(io_rdata_out);
    endproperty
    a_rdata_locked: assert property (p_rdata_locked) else $error("locked read data");

    property p_disabled_idle;
        @(posedge core_clk_in) disable iff (rst_in)
        !active_reg && !force_wr && !expired_reg |=> !expired_reg;
    endproperty
    a_disabled_idle: assert property (p_disabled_idle) else $error("disabled expiry");
endmodule

// ---- verif/host_model.sv ----
// Purpose: Host processor issuing I/O port cycles toward the watchdog
// Assumes: Strobes are one-cycle pulses driven just after the rising edge
// Notes: Address and data lines show inverted values while idle
module host_model (
    input wire logic core_clk_in,
    input wire logic [7:0] io_rdata_in,
    output wdt_pkg::io_req_t io_req_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import wdt_pkg::*;

    initial io_req_out = '0;

    // One strobed port cycle; idle lines flip so stale values never match
    task automatic io_cycle(input logic wr, input logic [7:0] addr, input logic [7:0] data);
        @(posedge core_clk_in);
        #1 io_req_out = '{wr: wr, rd: !wr, addr: addr, wdata: data};
        @(posedge core_clk_in);
        #1 io_req_out = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
    endtask

    // Index first, then the data port
    task automatic reg_write(input logic [7:0] idx, input logic [7:0] val);
        io_cycle(1'b1, INDEX_PORT_ADDR, idx);
        io_cycle(1'b1, DATA_PORT_ADDR, val);
    endtask

    // Read data lands one cycle after the read strobe
    task automatic reg_read(input logic [7:0] idx, output logic [7:0] val);
        io_cycle(1'b1, INDEX_PORT_ADDR, idx);
        io_cycle(1'b0, DATA_PORT_ADDR, 8'h00);
        @(posedge core_clk_in);
        #1 val = io_rdata_in;
    endtask

    // Key written twice in a row opens the port
    task automatic unlock();
        io_cycle(1'b1, INDEX_PORT_ADDR, UNLOCK_KEY);
        io_cycle(1'b1, INDEX_PORT_ADDR, UNLOCK_KEY);
    endtask

    // Lock key closes the port
    task automatic lock();
        io_cycle(1'b1, INDEX_PORT_ADDR, LOCK_KEY);
    endtask
endmodule

// ---- verif/testbench.sv ----
// Purpose: Self-checking bench for the config port watchdog
// Assumes: Units shortened to 10 cycles a second and 3 seconds a minute
// Notes: Expiry windows allow for the unit prescaler, which restarts on each count write
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import wdt_pkg::*;
    localparam int SEC = 10;
    localparam int MIN = 3;
    logic core_clk_in, rst_in, kbd, mouse, strap, irq_n, rst_out, hit;
    logic [7:0] io_rdata, rd;
    io_req_t io_req;
    int bad_count, checks, n;

    config_port_watchdog #(.SECOND_CYCLES(SEC), .MINUTE_SECONDS(MIN)) i_config_port_watchdog (
        .core_clk_in(core_clk_in), .rst_in(rst_in), .io_req_in(io_req),
        .io_rdata_out(io_rdata), .kbd_activity_in(kbd), .mouse_activity_in(mouse),
        .timeout_route_strap_in(strap), .timeout_irq_n_out(irq_n),
        .timeout_reset_out(rst_out));
    host_model i_host_model (.core_clk_in(core_clk_in), .io_rdata_in(io_rdata),
        .io_req_out(io_req));

    // Clock at 125 MHz
    initial begin
        core_clk_in = 1'b0;
        forever #4 core_clk_in = ~core_clk_in;
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    function automatic logic expired();
        return strap ? (rst_out === 1'b1) : (irq_n === 1'b0);
    endfunction

    // Count cycles until the timeout shows, bounded
    task automatic expect_expiry(input string name, input int lo, input int hi);
        for (n = 0; n < 2000 && !expired(); n++) @(posedge core_clk_in) #1;
        if (n >= 2000) begin
            check({name, " hang"}, 8'h01, 8'h00);
            finish_test();
        end else begin
            check(name, 8'(n >= lo && n <= hi), 8'h01);
        end
    endtask

    // Pulse an activity pin and note any timeout meanwhile
    task automatic kick(input logic use_mouse, input int times);
        hit = 1'b0;
        repeat (times * 6) begin
            @(posedge core_clk_in) #1;
            if (use_mouse) mouse = ((n++ % 6) < 3);
            else kbd = ((n++ % 6) < 3);
            hit |= expired();
        end
    endtask

    initial begin
        {kbd, mouse, strap, bad_count, checks, n} = '0;
        rst_in = 1'b1;
        repeat (5) @(posedge core_clk_in);
        #1 rst_in = 1'b0;
        check("irq idle", irq_n, 1'b1);
        check("reset idle", rst_out, 1'b0);
        // Locked port ignores everything
        i_host_model.reg_write(REG_UNIT_SELECT, WATCHDOG_UNIT);
        i_host_model.reg_write(REG_ACTIVATE, ACTIVATE_ON);
        i_host_model.reg_write(REG_COUNT, 8'h01);
        i_host_model.reg_read(REG_COUNT, rd);
        check("locked read", rd, 8'h00);
        kick(1'b0, 7);
        check("locked quiet", hit, 1'b0);
        $display("test locked done");
        // Seconds count expiry and status
        i_host_model.unlock();
        i_host_model.reg_write(REG_UNIT_SELECT, WATCHDOG_UNIT);
        i_host_model.reg_read(REG_COUNT, rd);
        check("count reset", rd, COUNT_RESET);
        i_host_model.reg_read(8'h55, rd);
        check("unmapped", rd, 8'h00);
        i_host_model.reg_read(REG_RESTART_STATUS, rd);
        check("kbd default", rd[KBD_EN_BIT], 1'b0);
        i_host_model.reg_write(REG_ACTIVATE, ACTIVATE_ON);
        i_host_model.reg_write(REG_COUNT, 8'h03);
        expect_expiry("3 s expiry", 2 * SEC, 3 * SEC + 4);
        repeat (20) @(posedge core_clk_in) #1;
        check("irq held", irq_n, 1'b0);
        check("route irq", rst_out, 1'b0);
        i_host_model.reg_read(REG_RESTART_STATUS, rd);
        check("status set", rd[STATUS_BIT], 1'b1);
        i_host_model.reg_write(REG_COUNT, 8'h05);
        check("restart", irq_n, 1'b1);
        expect_expiry("reload 5", 4 * SEC, 5 * SEC + 4);
        $display("test count done");
        // Keyboard and mouse restarts
        i_host_model.reg_write(REG_COUNT, 8'h05);
        kick(1'b0, 20);
        check("kbd off", hit, 1'b1);
        i_host_model.reg_write(REG_RESTART_STATUS, 8'h40);
        i_host_model.reg_write(REG_COUNT, 8'h05);
        kick(1'b0, 20);
        check("kbd on", hit, 1'b0);
        i_host_model.reg_write(REG_RESTART_STATUS, 8'h80);
        i_host_model.reg_write(REG_COUNT, 8'h05);
        kick(1'b1, 20);
        check("mouse on", hit, 1'b0);
        $display("test activity done");
        // Force, strap routing, minutes, stop, disable, lock
        i_host_model.reg_write(REG_COUNT, 8'h00);
        i_host_model.reg_write(REG_RESTART_STATUS, 8'h20);
        expect_expiry("force", 0, 3);
        i_host_model.reg_read(REG_RESTART_STATUS, rd);
        check("force clear", rd[FORCE_BIT], 1'b0);
        strap = 1'b1;
        repeat (4) @(posedge core_clk_in) #1;
        check("route reset", {rst_out, irq_n}, 8'h03);
        strap = 1'b0;
        i_host_model.reg_write(REG_UNIT_CFG, 8'h08);
        i_host_model.reg_write(REG_COUNT, 8'h02);
        expect_expiry("2 min", SEC * MIN, 2 * SEC * MIN + 4);
        i_host_model.reg_write(REG_UNIT_CFG, 8'h00);
        i_host_model.reg_write(REG_COUNT, 8'h00);
        kick(1'b1, 10);
        check("count zero", hit, 1'b0);
        i_host_model.reg_write(REG_ACTIVATE, 8'h00);
        i_host_model.reg_write(REG_COUNT, 8'h01);
        kick(1'b1, 10);
        check("disabled", hit, 1'b0);
        i_host_model.reg_write(REG_COUNT, 8'h00);
        i_host_model.reg_write(REG_ACTIVATE, ACTIVATE_ON);
        i_host_model.lock();
        i_host_model.reg_write(REG_COUNT, 8'h01);
        kick(1'b1, 10);
        check("relocked", hit, 1'b0);
        // Broken key sequence must fall back to locked
        i_host_model.io_cycle(1'b1, INDEX_PORT_ADDR, UNLOCK_KEY);
        i_host_model.io_cycle(1'b1, INDEX_PORT_ADDR, REG_COUNT);
        i_host_model.io_cycle(1'b1, INDEX_PORT_ADDR, UNLOCK_KEY);
        i_host_model.reg_write(REG_COUNT, 8'h01);
        kick(1'b1, 10);
        check("broken key", hit, 1'b0);
        $display("test misc done");
        // Mid-run reset comes back locked, zeroed and disabled
        rst_in = 1'b1;
        repeat (2) @(posedge core_clk_in);
        #1 rst_in = 1'b0;
        check("reset irq", irq_n, 1'b1);
        i_host_model.unlock();
        i_host_model.reg_write(REG_UNIT_SELECT, WATCHDOG_UNIT);
        i_host_model.reg_read(REG_COUNT, rd);
        check("reset count", rd, COUNT_RESET);
        i_host_model.reg_write(REG_COUNT, 8'h01);
        kick(1'b1, 10);
        check("reset disabled", hit, 1'b0);
        $display("test reset done");
        finish_test();
    end
endmodule
